// ---- hdl/tps_pkg.sv ----
// constants, types and state layout of the test port with shared pins
// Summary of operation
// - test select low: pins become test port, device held non-operational
// - test pins: clock on bit 0, mode 1, data in 2, out 3, reset 4
// - test select high: the five pins are plain general-purpose I/O
// - port follows the standard boundary-scan state machine and registers
// - decoder supports IDCODE BYPASS EXTEST SAMPLE PRELOAD HIGHZ CLAMP
// - identification instruction shifts out a fixed identification word
package tps_pkg;

  // widths
  localparam int unsigned TPS_GPIO_W = 5;
  localparam int unsigned TPS_IR_W = 4;
  localparam int unsigned TPS_ID_W = 32;
  localparam int unsigned TPS_BS_PINS = 4;
  localparam int unsigned TPS_BSR_W = 9;
  localparam int unsigned TPS_SYNC_W = 10;

  // shared pin positions in test mode
  localparam int unsigned TPS_PIN_TCK = 0;
  localparam int unsigned TPS_PIN_TMS = 1;
  localparam int unsigned TPS_PIN_TDI = 2;
  localparam int unsigned TPS_PIN_TDO = 3;
  localparam int unsigned TPS_PIN_TRST = 4;

  // synchroniser lane positions
  localparam int unsigned TPS_SY_GPIO = 0;
  localparam int unsigned TPS_SY_SEL = 5;
  localparam int unsigned TPS_SY_BS = 6;

  // boundary chain layout, bit 0 nearest data out
  localparam int unsigned TPS_BSR_IN_LSB = 0;
  localparam int unsigned TPS_BSR_OUT_LSB = 4;
  localparam int unsigned TPS_BSR_OE_BIT = 8;

  // instruction codes
  localparam logic [3:0] TPS_IR_EXTEST = 4'h0;
  localparam logic [3:0] TPS_IR_SAMPLE = 4'h1; // shared with preload
  localparam logic [3:0] TPS_IR_IDCODE = 4'h2;
  localparam logic [3:0] TPS_IR_HIGHZ = 4'h3;
  localparam logic [3:0] TPS_IR_CLAMP = 4'h4;
  localparam logic [3:0] TPS_IR_BYPASS = 4'hF;
  localparam logic [3:0] TPS_IR_CAPTURE = 4'h1;

  // identification word, value arbitrary, bit 0 set as required
  localparam logic [31:0] TPS_ID_WORD = 32'h0A5C_3001;

  // tap controller states
  typedef enum logic [3:0] {
    TPS_TLR, TPS_RTI, TPS_SEL_DR, TPS_CAP_DR, TPS_SH_DR, TPS_EX1_DR,
    TPS_PA_DR, TPS_EX2_DR, TPS_UPD_DR, TPS_SEL_IR, TPS_CAP_IR,
    TPS_SH_IR, TPS_EX1_IR, TPS_PA_IR, TPS_EX2_IR, TPS_UPD_IR
  } tps_tap_t;

  typedef enum logic [1:0] {TPS_DR_BYP, TPS_DR_ID, TPS_DR_BSR} tps_dr_t;

  // pad drive group
  typedef struct packed {
    logic [4:0] out;
    logic [4:0] oe;
  } tps_pad_t;

  // boundary pin drive group
  typedef struct packed {
    logic [3:0] out;
    logic oe;
  } tps_bs_t;

  // whole state of the port
  typedef struct packed {
    tps_tap_t tap;
    logic [3:0] ir_sh;
    logic [3:0] ir;
    logic byp;
    logic [31:0] id_sh;
    logic [8:0] bsr_sh;
    logic [8:0] bsr_upd;
    logic tdo;
    logic tdo_en;
    logic tck_prev;
    tps_pad_t pad;
    tps_bs_t bs;
    logic [4:0] core_gpio_in;
    logic [3:0] core_in;
    logic operational;
  } tps_state_t;

endpackage

// ---- hdl/tps_sync.sv ----
// two-flop synchroniser for pin inputs
module tps_sync #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // async in, synced out
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  logic [W-1:0] meta_q;

  // first stage feeds only the second; resets high so select reads inactive
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      meta_q <= '1;
      sync_o <= '1;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule

// ---- hdl/tps_top.sv ----
// boundary-scan test port sharing five general-purpose pins
module tps_top #(
  parameter logic [31:0] ID_WORD = tps_pkg::TPS_ID_WORD
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // shared pins and test select
  input wire logic test_mode_select_n_i,
  input wire logic [4:0] gpio_in_i,
  output logic [4:0] gpio_out_o,
  output logic [4:0] gpio_oe_o,
  // core side of the shared pins
  input wire tps_pkg::tps_pad_t core_gpio_i,
  output logic [4:0] core_gpio_in_o,
  // boundary-scanned device pins
  input wire logic [3:0] bs_pin_in_i,
  output logic [3:0] bs_pin_out_o,
  output logic bs_pin_oe_o,
  // core side of the scanned pins
  input wire tps_pkg::tps_bs_t core_bs_i,
  output logic [3:0] core_in_o,
  // device mode
  output logic operational_o
);

  tps_pkg::tps_state_t q, d;
  logic [tps_pkg::TPS_SYNC_W-1:0] sy;
  logic [4:0] gpio_s;
  logic [3:0] bs_in_s;
  logic sel_n_s, tck_s, tms_s, tdi_s, trst_n_s, rise, fall;
  tps_pkg::tps_dr_t dsel;

  // standard tap transitions on each clock rise
  function automatic tps_pkg::tps_tap_t tps_next(
    input tps_pkg::tps_tap_t s, input logic tms);
    case (s)
      tps_pkg::TPS_TLR: tps_next = tms ? tps_pkg::TPS_TLR : tps_pkg::TPS_RTI;
      tps_pkg::TPS_RTI:
        tps_next = tms ? tps_pkg::TPS_SEL_DR : tps_pkg::TPS_RTI;
      tps_pkg::TPS_SEL_DR:
        tps_next = tms ? tps_pkg::TPS_SEL_IR : tps_pkg::TPS_CAP_DR;
      tps_pkg::TPS_CAP_DR:
        tps_next = tms ? tps_pkg::TPS_EX1_DR : tps_pkg::TPS_SH_DR;
      tps_pkg::TPS_SH_DR:
        tps_next = tms ? tps_pkg::TPS_EX1_DR : tps_pkg::TPS_SH_DR;
      tps_pkg::TPS_EX1_DR:
        tps_next = tms ? tps_pkg::TPS_UPD_DR : tps_pkg::TPS_PA_DR;
      tps_pkg::TPS_PA_DR:
        tps_next = tms ? tps_pkg::TPS_EX2_DR : tps_pkg::TPS_PA_DR;
      tps_pkg::TPS_EX2_DR:
        tps_next = tms ? tps_pkg::TPS_UPD_DR : tps_pkg::TPS_SH_DR;
      tps_pkg::TPS_UPD_DR:
        tps_next = tms ? tps_pkg::TPS_SEL_DR : tps_pkg::TPS_RTI;
      tps_pkg::TPS_SEL_IR:
        tps_next = tms ? tps_pkg::TPS_TLR : tps_pkg::TPS_CAP_IR;
      tps_pkg::TPS_CAP_IR:
        tps_next = tms ? tps_pkg::TPS_EX1_IR : tps_pkg::TPS_SH_IR;
      tps_pkg::TPS_SH_IR:
        tps_next = tms ? tps_pkg::TPS_EX1_IR : tps_pkg::TPS_SH_IR;
      tps_pkg::TPS_EX1_IR:
        tps_next = tms ? tps_pkg::TPS_UPD_IR : tps_pkg::TPS_PA_IR;
      tps_pkg::TPS_PA_IR:
        tps_next = tms ? tps_pkg::TPS_EX2_IR : tps_pkg::TPS_PA_IR;
      tps_pkg::TPS_EX2_IR:
        tps_next = tms ? tps_pkg::TPS_UPD_IR : tps_pkg::TPS_SH_IR;
      tps_pkg::TPS_UPD_IR:
        tps_next = tms ? tps_pkg::TPS_SEL_DR : tps_pkg::TPS_RTI;
      default: tps_next = tps_pkg::TPS_TLR;
    endcase
  endfunction

  // data register chosen by an instruction; unknown codes fall to bypass
  function automatic tps_pkg::tps_dr_t tps_dr_of(input logic [3:0] ir);
    case (ir)
      tps_pkg::TPS_IR_IDCODE: tps_dr_of = tps_pkg::TPS_DR_ID;
      tps_pkg::TPS_IR_EXTEST, tps_pkg::TPS_IR_SAMPLE:
        tps_dr_of = tps_pkg::TPS_DR_BSR;
      default: tps_dr_of = tps_pkg::TPS_DR_BYP;
    endcase
  endfunction

  // every pin input crosses two flops before use
  tps_sync #(.W(tps_pkg::TPS_SYNC_W)) u_sync (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .async_i({bs_pin_in_i, test_mode_select_n_i, gpio_in_i}),
    .sync_o(sy)
  );

  // lane split of the synced inputs
  assign gpio_s = sy[tps_pkg::TPS_SY_GPIO +: tps_pkg::TPS_GPIO_W];
  assign sel_n_s = sy[tps_pkg::TPS_SY_SEL];
  assign bs_in_s = sy[tps_pkg::TPS_SY_BS +: tps_pkg::TPS_BS_PINS];
  assign tck_s = gpio_s[tps_pkg::TPS_PIN_TCK];
  assign tms_s = gpio_s[tps_pkg::TPS_PIN_TMS];
  assign tdi_s = gpio_s[tps_pkg::TPS_PIN_TDI];
  assign trst_n_s = gpio_s[tps_pkg::TPS_PIN_TRST];
  // test clock edges seen by the system clock, 250 MHz oversamples well
  assign rise = tck_s & ~q.tck_prev;
  assign fall = ~tck_s & q.tck_prev;
  assign dsel = tps_dr_of(q.ir);

  // next state of the whole port
  always_comb begin
    d = q;
    d.tck_prev = tck_s;
    if (sel_n_s || !trst_n_s) begin
      // outside test mode the tap idles in reset, ready for entry
      d.tap = tps_pkg::TPS_TLR;
      d.ir = tps_pkg::TPS_IR_IDCODE;
      d.tdo_en = 1'b0;
    end else begin
      if (rise) begin
        case (q.tap)
          tps_pkg::TPS_CAP_IR: d.ir_sh = tps_pkg::TPS_IR_CAPTURE;
          tps_pkg::TPS_SH_IR: d.ir_sh = {tdi_s, q.ir_sh[3:1]};
          tps_pkg::TPS_CAP_DR: begin
            d.byp = 1'b0;
            d.id_sh = ID_WORD;
            d.bsr_sh = {core_bs_i.oe, core_bs_i.out, bs_in_s};
          end
          tps_pkg::TPS_SH_DR: begin
            case (dsel)
              tps_pkg::TPS_DR_ID: d.id_sh = {tdi_s, q.id_sh[31:1]};
              tps_pkg::TPS_DR_BSR: d.bsr_sh = {tdi_s, q.bsr_sh[8:1]};
              default: d.byp = tdi_s;
            endcase
          end
          default: d.byp = q.byp;
        endcase
        d.tap = tps_next(q.tap, tms_s);
      end
      // data out and updates move on the falling edge
      if (fall) begin
        d.tdo_en = (q.tap == tps_pkg::TPS_SH_IR) ||
                   (q.tap == tps_pkg::TPS_SH_DR);
        case (q.tap)
          tps_pkg::TPS_SH_IR: d.tdo = q.ir_sh[0];
          tps_pkg::TPS_SH_DR: begin
            case (dsel)
              tps_pkg::TPS_DR_ID: d.tdo = q.id_sh[0];
              tps_pkg::TPS_DR_BSR: d.tdo = q.bsr_sh[0];
              default: d.tdo = q.byp;
            endcase
          end
          tps_pkg::TPS_UPD_IR: d.ir = q.ir_sh;
          tps_pkg::TPS_UPD_DR: begin
            // preload shares the sample code, so both refresh the latches
            if (dsel == tps_pkg::TPS_DR_BSR) begin
              d.bsr_upd = q.bsr_sh;
            end
          end
          default: d.tdo = q.tdo;
        endcase
      end
      if (d.tap == tps_pkg::TPS_TLR) begin
        d.ir = tps_pkg::TPS_IR_IDCODE;
      end
    end
    // shared pads: plain gpio or test port
    if (sel_n_s) begin
      d.pad = core_gpio_i;
      d.core_gpio_in = gpio_s;
      d.operational = 1'b1;
    end else begin
      d.pad.out = '0;
      d.pad.oe = '0;
      d.pad.out[tps_pkg::TPS_PIN_TDO] = q.tdo;
      d.pad.oe[tps_pkg::TPS_PIN_TDO] = q.tdo_en;
      d.core_gpio_in = '0;
      d.operational = 1'b0;
    end
    // scanned pins follow the instruction only in test mode
    d.bs = core_bs_i;
    d.core_in = bs_in_s;
    if (!sel_n_s) begin
      case (q.ir)
        tps_pkg::TPS_IR_EXTEST, tps_pkg::TPS_IR_CLAMP: begin
          d.bs.out =
            q.bsr_upd[tps_pkg::TPS_BSR_OUT_LSB +: tps_pkg::TPS_BS_PINS];
          d.bs.oe = q.bsr_upd[tps_pkg::TPS_BSR_OE_BIT];
          d.core_in =
            q.bsr_upd[tps_pkg::TPS_BSR_IN_LSB +: tps_pkg::TPS_BS_PINS];
        end
        tps_pkg::TPS_IR_HIGHZ: begin
          d.bs.out = '0;
          d.bs.oe = 1'b0;
        end
        default: d.bs = core_bs_i;
      endcase
    end
  end

  // state register; pads start as released inputs
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      q <= '0;
      q.tap <= tps_pkg::TPS_TLR;
      q.ir <= tps_pkg::TPS_IR_IDCODE;
      q.tck_prev <= 1'b1;
      q.operational <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // outputs straight from the state register
  assign gpio_out_o = q.pad.out;
  assign gpio_oe_o = q.pad.oe;
  assign core_gpio_in_o = q.core_gpio_in;
  assign bs_pin_out_o = q.bs.out;
  assign bs_pin_oe_o = q.bs.oe;
  assign core_in_o = q.core_in;
  assign operational_o = q.operational;

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  chk_test_not_oper: assert property (!sel_n_s |=> !operational_o)
    else $error("device operational in test mode");
  chk_gpio_passthru: assert property (sel_n_s |=>
    gpio_out_o == $past(core_gpio_i.out) &&
    gpio_oe_o == $past(core_gpio_i.oe))
    else $error("gpio not passed through in normal mode");
  chk_test_pad_oe: assert property (!sel_n_s && !q.tdo_en |=>
    gpio_oe_o == 5'h00)
    else $error("test pad driven outside shift");
  chk_trst_forces: assert property (!sel_n_s && !trst_n_s |=>
    q.tap == tps_pkg::TPS_TLR && q.ir == tps_pkg::TPS_IR_IDCODE)
    else $error("test reset did not reset tap");
  chk_tlr_to_idle: assert property (!sel_n_s && trst_n_s && rise &&
    !tms_s && q.tap == tps_pkg::TPS_TLR |=> q.tap == tps_pkg::TPS_RTI)
    else $error("tap did not leave reset");
  chk_ir_capture: assert property (!sel_n_s && trst_n_s && rise &&
    q.tap == tps_pkg::TPS_CAP_IR |=> q.ir_sh == tps_pkg::TPS_IR_CAPTURE)
    else $error("wrong instruction capture value");
  chk_id_capture: assert property (!sel_n_s && trst_n_s && rise &&
    q.tap == tps_pkg::TPS_CAP_DR |=> q.id_sh == ID_WORD)
    else $error("identification word not captured");
  chk_highz_pins: assert property (!sel_n_s &&
    q.ir == tps_pkg::TPS_IR_HIGHZ |=> !bs_pin_oe_o)
    else $error("pins driven under highz");
  chk_tdo_follow: assert property (!sel_n_s && trst_n_s && fall &&
    q.tap == tps_pkg::TPS_SH_IR |=>
    ##1 gpio_out_o[tps_pkg::TPS_PIN_TDO] == $past(q.ir_sh[0], 2))
    else $error("data out does not follow instruction shift");

  cov_id_shift: cover property (q.tap == tps_pkg::TPS_SH_DR &&
    q.ir == tps_pkg::TPS_IR_IDCODE);
  cov_ir_update: cover property (fall && q.tap == tps_pkg::TPS_UPD_IR);
  cov_extest: cover property (!sel_n_s && q.ir == tps_pkg::TPS_IR_EXTEST);
  cov_leave_test: cover property (!sel_n_s ##1 sel_n_s);

endmodule

// ---- tb/tps_jtag_host.sv ----
// behavioural boundary-scan controller on the far side of the test pins
module tps_jtag_host (
  // clock
  input wire logic clk_i,
  // test pins
  input wire logic tdo_i,
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o,
  output logic trst_n_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // tck idles low between frames
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b0;
    trst_n_o = 1'b1;
  end

  // one tck period, 20 clk a half; tdo taken just before the rise
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    tms_o <= tms;
    tdi_o <= tdi;
    repeat (20) @(posedge clk_i);
    tdo = tdo_i;
    tck_o <= 1'b1;
    repeat (20) @(posedge clk_i);
    tck_o <= 1'b0;
  endtask

  // five ones reach reset from any state, then on to idle
  task automatic go_idle();
    logic o;
    repeat (5) step(1'b1, 1'b0, o);
    step(1'b0, 1'b1, o);
  endtask

  // scan n bits lsb first through ir or dr, idle to idle
  task automatic scan(input logic ir, input logic [31:0] din, input int n,
    output logic [31:0] dout);
    logic o;
    dout = '0;
    step(1'b1, 1'b0, o);
    if (ir) begin
      step(1'b1, 1'b1, o);
    end
    step(1'b0, 1'b0, o);
    step(1'b0, 1'b1, o);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], o);
      dout[i] = o;
    end
    step(1'b1, 1'b0, o);
    step(1'b0, 1'b1, o);
  endtask

  // test reset low while tck stands still
  task automatic pulse_trst();
    trst_n_o <= 1'b0;
    repeat (8) @(posedge clk_i);
    trst_n_o <= 1'b1;
    repeat (4) @(posedge clk_i);
  endtask
endmodule

// ---- tb/tps_top_bench.sv ----
// self-checking bench for the shared-pin test port
module tps_top_bench;
  timeunit 1ns;
  timeprecision 1ps;

  // identification word for this run, value arbitrary
  localparam logic [31:0] ID = 32'h1357_9BDF;
  logic clk_i, reset_i, sel_n, oper, bs_oe, tck, tms, tdi, trst_n;
  logic [4:0] drv, ext, pad, gpio_out, gpio_oe, core_gin;
  logic [3:0] bs_in, bs_out, core_in;
  logic [31:0] d;
  tps_pkg::tps_pad_t core_gpio;
  tps_pkg::tps_bs_t core_bs;
  int num_errors = 0;
  int total_checks = 0;

  // pad level: design drive wins, else far side; tdo line otherwise toggles
  assign ext = sel_n ? drv : {trst_n, ~tck, tdi, tms, tck};
  assign pad = (gpio_oe & gpio_out) | (~gpio_oe & ext);

  tps_top #(.ID_WORD(ID)) u_tps_top (
    .clk_i(clk_i), .reset_i(reset_i), .test_mode_select_n_i(sel_n),
    .gpio_in_i(pad), .gpio_out_o(gpio_out), .gpio_oe_o(gpio_oe),
    .core_gpio_i(core_gpio), .core_gpio_in_o(core_gin),
    .bs_pin_in_i(bs_in), .bs_pin_out_o(bs_out), .bs_pin_oe_o(bs_oe),
    .core_bs_i(core_bs), .core_in_o(core_in), .operational_o(oper)
  );

  tps_jtag_host u_tps_jtag_host (
    .clk_i(clk_i), .tdo_i(pad[3]), .tck_o(tck), .tms_o(tms),
    .tdi_o(tdi), .trst_n_o(trst_n)
  );

  // 250 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  task automatic check(input string name, input logic [31:0] exp,
    input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask

  task automatic complete_run();
    if (num_errors == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // normal mode: pads carry core drive, pad levels reach the core
  task automatic t_normal();
    core_gpio <= tps_pkg::tps_pad_t'({5'h15, 5'h0F});
    drv <= 5'h1A;
    repeat (6) @(posedge clk_i);
    check("gpio out", 5'h15, gpio_out);
    check("gpio oe", 5'h0F, gpio_oe);
    check("core gpio in", 5'h15, core_gin);
    check("operational", 1'b1, oper);
  endtask

  // select low: pins turn to test port, device stops
  task automatic t_enter();
    sel_n <= 1'b0;
    repeat (6) @(posedge clk_i);
    check("operational", 1'b0, oper);
    check("gpio oe", 5'h00, gpio_oe);
    check("core gpio in", 5'h00, core_gin);
    u_tps_jtag_host.go_idle();
  endtask

  // identification word shifts out after reset, tdo on pin 3
  task automatic t_idcode();
    u_tps_jtag_host.scan(1'b0, 32'h0, 32, d);
    check("id word", ID, d);
  endtask

  // ir capture pattern, then one-cycle bypass delay
  task automatic t_bypass();
    u_tps_jtag_host.scan(1'b1, 32'hF, 4, d);
    check("ir capture", 4'h1, d[3:0]);
    u_tps_jtag_host.scan(1'b0, 32'hB5, 8, d);
    check("bypass", 8'h6A, d[7:0]);
  endtask

  // sample captures pins, preload then extest drives the latches
  task automatic t_extest();
    bs_in <= 4'hA;
    core_bs <= tps_pkg::tps_bs_t'({4'h5, 1'b1});
    u_tps_jtag_host.scan(1'b1, 32'h1, 4, d);
    u_tps_jtag_host.scan(1'b0, 32'h1C6, 9, d);
    check("sample capture", 9'h15A, d[8:0]);
    check("pin out sample", 4'h5, bs_out);
    core_bs <= tps_pkg::tps_bs_t'({4'h3, 1'b0});
    u_tps_jtag_host.scan(1'b1, 32'h0, 4, d);
    check("pin out extest", 4'hC, bs_out);
    check("pin oe extest", 1'b1, bs_oe);
    check("core in extest", 4'h6, core_in);
  endtask

  // highz floats the pins, clamp drives the latches again
  task automatic t_highz_clamp();
    u_tps_jtag_host.scan(1'b1, 32'h3, 4, d);
    check("pin out highz", 4'h0, bs_out);
    check("pin oe highz", 1'b0, bs_oe);
    u_tps_jtag_host.scan(1'b1, 32'h4, 4, d);
    check("pin out clamp", 4'hC, bs_out);
    check("pin oe clamp", 1'b1, bs_oe);
  endtask

  // test reset without tck restores identification instruction
  task automatic t_trst();
    u_tps_jtag_host.pulse_trst();
    check("pin out after trst", 4'h3, bs_out);
    u_tps_jtag_host.step(1'b0, 1'b0, d[0]);
    u_tps_jtag_host.scan(1'b0, 32'h0, 32, d);
    check("id after trst", ID, d);
  endtask

  // release select with a master reset, pins back to core
  task automatic t_exit();
    sel_n <= 1'b1;
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    check("operational", 1'b1, oper);
    check("gpio out", 5'h15, gpio_out);
    check("gpio oe", 5'h0F, gpio_oe);
  endtask

  // main sequence
  initial begin
    reset_i = 1'b1;
    sel_n = 1'b1;
    drv = 5'h00;
    core_gpio = '0;
    bs_in = 4'h0;
    core_bs = '0;
    repeat (6) @(posedge clk_i);
    reset_i <= 1'b0;
    t_normal();
    t_enter();
    t_idcode();
    t_bypass();
    t_extest();
    t_highz_clamp();
    t_trst();
    t_exit();
    complete_run();
  end

  // cut a hang short
  initial begin
    #300us;
    num_errors++;
    complete_run();
  end
endmodule
